// ### core/sgp_port.sv
// Six-bit general-purpose port: latch, direction, analog select, pad controls.
// Assumes a plain register port on ref_clk and pads resolved by the testbench.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module sgp_port
    import sgp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire sgp_addr_t reg_addr,
    input wire sgp_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sgp_data_t reg_rdata,
    input wire sgp_pins_t pad_in,
    output sgp_pins_t pad_out,
    output sgp_pins_t pad_oe,
    output sgp_pins_t pad_slew_limit,
    output sgp_pins_t pad_ttl_sel,
    output sgp_pins_t pad_pullup_en,
    output sgp_pins_t pin_level,
    input wire sgp_pins_t periph_override,
    input wire sgp_pins_t periph_value,
    input wire sgp_pins_t periph_open_drain,
    input wire sgp_pins_t analog_out_en,
    input wire logic master_clear_enable
);

    // Pins and the strap come from outside ref_clk, so they are synchronised.
    sgp_pins_t pin_meta_r;
    sgp_pins_t pin_sync_r;
    logic mclr_meta_r;
    logic mclr_sync_r;
    sgp_pins_t output_latch_reg;
    sgp_pins_t direction_reg;
    sgp_pins_t analog_select_reg;
    sgp_pins_t weak_pullup_reg;
    sgp_pins_t open_drain_select_reg;
    sgp_pins_t slew_limit_reg;
    sgp_pins_t input_threshold_reg;
    sgp_pins_t pin_level_nxt;
    sgp_pins_t latch_nxt;
    sgp_pins_t drive_val;
    sgp_pins_t drive_en;
    sgp_pins_t od_eff;
    sgp_pins_t oe_nxt;
    sgp_pins_t out_nxt;
    sgp_pins_t pu_nxt;
    sgp_data_t rdata_nxt;
    logic [2:0] bit_idx;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            mclr_meta_r <= 1'b0;
            mclr_sync_r <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_meta_r <= pad_in;
            pin_sync_r <= pin_meta_r;
            mclr_meta_r <= master_clear_enable;
            mclr_sync_r <= mclr_meta_r;
        end
    end

    // The threshold choice is applied inside the pad; only the buffered level arrives here.
    always_comb
    begin
        pin_level_nxt = pin_sync_r & ~analog_select_reg;
        if (mclr_sync_r)
        begin
            pin_level_nxt[`SGP_RO_BIT] = 1'b1;
        end
    end

    always_comb
    begin
        bit_idx = reg_wdata[`SGP_BITOP_IDX_LSB +: 3];
        latch_nxt = output_latch_reg;
        if (reg_wr && (reg_addr == `SGP_OFS_LATCH || reg_addr == `SGP_OFS_PIN_LEVEL))
        begin
            latch_nxt = reg_wdata[`SGP_WIDTH-1:0] & `SGP_IMPL_MASK;
        end
        else if (reg_wr && reg_addr == `SGP_OFS_BITOP && bit_idx < 3'(`SGP_WIDTH))
        begin
            // Read-modify-write starts from pin levels, so analog pins can clear latch bits.
            latch_nxt = pin_level_nxt & `SGP_IMPL_MASK;
            latch_nxt[bit_idx] = reg_wdata[`SGP_BITOP_VAL_BIT];
            // Masking after the bit update keeps the unimplemented bit at zero.
            latch_nxt = latch_nxt & `SGP_IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_latch_reg <= `SGP_RST_LATCH;
        end
        else if (clk_en)
        begin
            output_latch_reg <= latch_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            direction_reg <= `SGP_RST_DIRECTION;
            analog_select_reg <= `SGP_RST_ANALOG;
            weak_pullup_reg <= `SGP_RST_PULLUP;
            open_drain_select_reg <= `SGP_RST_OPEN_DRAIN;
            slew_limit_reg <= `SGP_RST_SLEW;
            input_threshold_reg <= `SGP_RST_THRESHOLD;
        end
        else if (clk_en && reg_wr)
        begin
            unique case (reg_addr)
                `SGP_OFS_DIRECTION:
                begin
                    direction_reg <= reg_wdata[`SGP_WIDTH-1:0] | ~`SGP_IMPL_MASK;
                end
                `SGP_OFS_ANALOG:
                begin
                    analog_select_reg <= reg_wdata[`SGP_WIDTH-1:0] & `SGP_IMPL_MASK;
                end
                `SGP_OFS_PULLUP:
                begin
                    weak_pullup_reg <= reg_wdata[`SGP_WIDTH-1:0];
                end
                `SGP_OFS_OPEN_DRAIN:
                begin
                    open_drain_select_reg <= reg_wdata[`SGP_WIDTH-1:0] & `SGP_IMPL_MASK;
                end
                `SGP_OFS_SLEW:
                begin
                    slew_limit_reg <= reg_wdata[`SGP_WIDTH-1:0] & `SGP_IMPL_MASK;
                end
                `SGP_OFS_THRESHOLD:
                begin
                    input_threshold_reg <= reg_wdata[`SGP_WIDTH-1:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    // Output source priority: analog output, then peripheral, then latch.
    always_comb
    begin
        drive_val = output_latch_reg;
        drive_en = ~direction_reg;
        for (int i = 0; i < `SGP_WIDTH; i++)
        begin
            if (periph_override[i])
            begin
                drive_val[i] = periph_value[i];
            end
        end
        drive_en = drive_en & ~analog_out_en;
        od_eff = open_drain_select_reg | periph_open_drain;
        oe_nxt = drive_en & ~(od_eff & drive_val);
        out_nxt = drive_val & ~od_eff;
        // Outputs lose the pull-up unless open-drain and released high.
        pu_nxt = weak_pullup_reg & (~drive_en | (od_eff & drive_val));
        if (mclr_sync_r)
        begin
            pu_nxt[`SGP_RO_BIT] = 1'b1;
        end
        oe_nxt[`SGP_RO_BIT] = 1'b0;
        out_nxt[`SGP_RO_BIT] = 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_out <= '0;
            pad_oe <= '0;
            pad_pullup_en <= '0;
            pad_slew_limit <= `SGP_RST_SLEW;
            pad_ttl_sel <= '0;
            pin_level <= '0;
        end
        else if (clk_en)
        begin
            pad_out <= out_nxt;
            pad_oe <= oe_nxt;
            pad_pullup_en <= pu_nxt;
            pad_slew_limit <= slew_limit_reg;
            pad_ttl_sel <= input_threshold_reg;
            pin_level <= pin_level_nxt;
        end
    end

    always_comb
    begin
        rdata_nxt = '0;
        unique case (reg_addr)
            `SGP_OFS_PIN_LEVEL: rdata_nxt[`SGP_WIDTH-1:0] = pin_level_nxt;
            `SGP_OFS_LATCH: rdata_nxt[`SGP_WIDTH-1:0] = output_latch_reg;
            `SGP_OFS_DIRECTION: rdata_nxt[`SGP_WIDTH-1:0] = direction_reg;
            `SGP_OFS_ANALOG: rdata_nxt[`SGP_WIDTH-1:0] = analog_select_reg;
            `SGP_OFS_PULLUP: rdata_nxt[`SGP_WIDTH-1:0] = weak_pullup_reg;
            `SGP_OFS_OPEN_DRAIN: rdata_nxt[`SGP_WIDTH-1:0] = open_drain_select_reg;
            `SGP_OFS_SLEW: rdata_nxt[`SGP_WIDTH-1:0] = slew_limit_reg;
            `SGP_OFS_THRESHOLD: rdata_nxt[`SGP_WIDTH-1:0] = input_threshold_reg;
            default: rdata_nxt = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe; otherwise zero.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= '0;
        end
        else if (clk_en)
        begin
            reg_rdata <= reg_rd ? rdata_nxt : '0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    AST_DIR_BIT3: assert property (direction_reg[`SGP_RO_BIT])
        else $error("input-only direction bit cleared");
    AST_NO_DRIVE_BIT3: assert property (!pad_oe[`SGP_RO_BIT])
        else $error("input-only pin driven");
    AST_INPUT_TRISTATE: assert property (clk_en && direction_reg[0] |=> !pad_oe[0])
        else $error("input pin drives");
    AST_ANALOG_OUT_HIZ: assert property (clk_en && analog_out_en[1] |=> !pad_oe[1])
        else $error("analog output did not release driver");
    AST_ANALOG_READ_ZERO: assert property (clk_en && analog_select_reg[2] |=> !pin_level[2])
        else $error("analog pin read nonzero");
    AST_LATCH_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_PIN_LEVEL
        |=> output_latch_reg == ($past(reg_wdata[`SGP_WIDTH-1:0]) & `SGP_IMPL_MASK))
        else $error("pin register write missed latch");
    AST_READ_LATCH: assert property (clk_en && reg_rd && reg_addr == `SGP_OFS_LATCH
        |=> reg_rdata[`SGP_WIDTH-1:0] == $past(output_latch_reg))
        else $error("latch read mismatch");
    AST_OD_NO_SOURCE: assert property (clk_en && open_drain_select_reg[0] |=> !(pad_oe[0] && pad_out[0]))
        else $error("open-drain pin sourced current");
    AST_MCLR_READ: assert property (mclr_sync_r && clk_en |=> pin_level[`SGP_RO_BIT])
        else $error("master clear pin read low");
    AST_PU_OUTPUT: assert property (clk_en && !direction_reg[4] && !od_eff[4] |=> !pad_pullup_en[4])
        else $error("pull-up on a push-pull output");

    // Register writes land one edge after the strobe.
    AST_DIR_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_DIRECTION
        |=> direction_reg == ($past(reg_wdata[`SGP_WIDTH-1:0]) | ~`SGP_IMPL_MASK))
        else $error("direction write mismatch");

    AST_ANALOG_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_ANALOG
        |=> analog_select_reg == ($past(reg_wdata[`SGP_WIDTH-1:0]) & `SGP_IMPL_MASK))
        else $error("analog select write mismatch");

    AST_OD_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_OPEN_DRAIN
        |=> open_drain_select_reg == ($past(reg_wdata[`SGP_WIDTH-1:0]) & `SGP_IMPL_MASK))
        else $error("open-drain write mismatch");

    AST_SLEW_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_SLEW
        |=> slew_limit_reg == ($past(reg_wdata[`SGP_WIDTH-1:0]) & `SGP_IMPL_MASK))
        else $error("slew write mismatch");

    AST_THRESH_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_THRESHOLD
        |=> input_threshold_reg == $past(reg_wdata[`SGP_WIDTH-1:0]))
        else $error("threshold write mismatch");

    AST_PULLUP_WRITE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_PULLUP
        |=> weak_pullup_reg == $past(reg_wdata[`SGP_WIDTH-1:0]))
        else $error("pull-up write mismatch");

    AST_LATCH_DIRECT: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_LATCH
        |=> output_latch_reg == ($past(reg_wdata[`SGP_WIDTH-1:0]) & `SGP_IMPL_MASK))
        else $error("latch write mismatch");

    AST_BITOP_SET: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_BITOP
        && reg_wdata[`SGP_BITOP_IDX_LSB +: 3] == 3'h0
        |=> output_latch_reg[0] == $past(reg_wdata[`SGP_BITOP_VAL_BIT]))
        else $error("bit write missed its bit");

    AST_BITOP_RANGE: assert property (clk_en && reg_wr && reg_addr == `SGP_OFS_BITOP
        && reg_wdata[`SGP_BITOP_IDX_LSB +: 3] > 3'h5 |=> $stable(output_latch_reg))
        else $error("out-of-range bit write changed latch");

    AST_LATCH_HOLD: assert property (clk_en && !reg_wr |=> $stable(output_latch_reg))
        else $error("latch changed without a write");

    AST_LATCH_IMPL: assert property ((output_latch_reg & ~`SGP_IMPL_MASK) == 6'h00)
        else $error("unimplemented latch bit set");

    AST_ANALOG_IMPL: assert property (!analog_select_reg[`SGP_RO_BIT])
        else $error("unimplemented analog bit set");

    AST_PAD_OUT_BIT3: assert property (!pad_out[`SGP_RO_BIT])
        else $error("input-only pin output high");

    // Pad controls follow their sources one edge later.
    AST_OUTPUT_DRIVE: assert property (clk_en && !direction_reg[5] && !analog_out_en[5] && !od_eff[5]
        |=> pad_oe[5])
        else $error("output pin not driven");

    AST_OUT_VALUE: assert property (clk_en && !periph_override[5] && !od_eff[5]
        |=> pad_out[5] == $past(output_latch_reg[5]))
        else $error("latch value not on pad");

    AST_PERIPH_VALUE: assert property (clk_en && periph_override[0] && !od_eff[0]
        |=> pad_out[0] == $past(periph_value[0]))
        else $error("peripheral value not on pad");

    AST_PERIPH_ANALOG: assert property (clk_en && periph_override[1] && analog_select_reg[1]
        && !direction_reg[1] && !analog_out_en[1] && !od_eff[1] |=> pad_oe[1])
        else $error("analog-mode pin lost digital drive");

    AST_I2C_OD: assert property (clk_en && periph_open_drain[2] |=> !(pad_oe[2] && pad_out[2]))
        else $error("owned pin sourced current");

    AST_PU_DRIVE_LOW: assert property (clk_en && drive_en[0] && !drive_val[0] |=> !pad_pullup_en[0])
        else $error("pull-up on an output driven low");

    AST_MCLR_PULLUP: assert property (clk_en && mclr_sync_r |=> pad_pullup_en[`SGP_RO_BIT])
        else $error("master clear pull-up off");

    AST_SLEW_COPY: assert property (clk_en |=> pad_slew_limit == $past(slew_limit_reg))
        else $error("slew pad control stale");

    AST_TTL_COPY: assert property (clk_en |=> pad_ttl_sel == $past(input_threshold_reg))
        else $error("threshold pad control stale");

    // Read data stand for one cycle only and never carry analog levels.
    AST_RDATA_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without a read");

    AST_RDATA_UPPER: assert property (reg_rdata[7:6] == 2'b00)
        else $error("upper read bits set");

    AST_PIN_READ_ANALOG: assert property (clk_en && reg_rd && reg_addr == `SGP_OFS_PIN_LEVEL
        |=> (reg_rdata[`SGP_WIDTH-1:0] & $past(analog_select_reg)) == 6'h00)
        else $error("analog pin read nonzero on the bus");


    COV_DRIVE: cover property (pad_oe[0] && pad_out[0]);
    COV_PERIPH: cover property (periph_override[1] && pad_oe[1]);
    COV_BITOP: cover property (reg_wr && reg_addr == `SGP_OFS_BITOP);
    COV_ANALOG: cover property (analog_select_reg == '0);

endmodule

`default_nettype wire

// ### core/sgp_defines.svh
// Register offsets, field positions, reset values and widths of the six-bit port.
// Assumes inclusion by its bare name from the package; the port module uses its macros without including it.
`ifndef SGP_DEFINES_SVH
`define SGP_DEFINES_SVH

`define SGP_WIDTH 6
`define SGP_ADDR_W 4
`define SGP_DATA_W 8
`define SGP_RO_BIT 3

`define SGP_OFS_PIN_LEVEL 4'h0
`define SGP_OFS_LATCH 4'h1
`define SGP_OFS_DIRECTION 4'h2
`define SGP_OFS_ANALOG 4'h3
`define SGP_OFS_PULLUP 4'h4
`define SGP_OFS_OPEN_DRAIN 4'h5
`define SGP_OFS_SLEW 4'h6
`define SGP_OFS_THRESHOLD 4'h7
`define SGP_OFS_BITOP 4'h8

`define SGP_RST_DIRECTION 6'h3f
`define SGP_RST_ANALOG 6'h37
`define SGP_RST_PULLUP 6'h00
`define SGP_RST_OPEN_DRAIN 6'h00
`define SGP_RST_SLEW 6'h37
`define SGP_RST_THRESHOLD 6'h3f
`define SGP_RST_LATCH 6'h00
`define SGP_IMPL_MASK 6'h37

`define SGP_BITOP_IDX_LSB 0
`define SGP_BITOP_VAL_BIT 4

`endif

// ### core/sgp_pkg.sv
// Types shared by the six-bit port design.
// Assumes sgp_defines.svh is on the include path.
`include "sgp_defines.svh"

package sgp_pkg;
    typedef logic [`SGP_WIDTH-1:0] sgp_pins_t;
    typedef logic [`SGP_DATA_W-1:0] sgp_data_t;
    typedef logic [`SGP_ADDR_W-1:0] sgp_addr_t;
endpackage

// ### bench/sgp_pad_model.sv
// Board-side model of the six port pads: drive from the port, an external source, or a pull-up.
// Assumes pad controls from sgp_port and a testbench that chooses the external drive.
`timescale 1ns/100ps
`default_nettype none

module sgp_pad_model
    import sgp_pkg::*;
(
    input wire logic ref_clk,
    input wire sgp_pins_t pad_out,
    input wire sgp_pins_t pad_oe,
    input wire sgp_pins_t pad_pullup_en,
    input wire sgp_pins_t ext_val,
    input wire sgp_pins_t ext_en,
    output sgp_pins_t pad_in
);
    sgp_pins_t float_r = 6'h00;

    // A floating pad toggles every cycle so that no read can lean on a stale level.
    always @(posedge ref_clk)
    begin
        float_r <= ~float_r;
    end

    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            // The device driver wins over the board source; open-drain high is left to the board source, then the pull-up.
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup_en[i] ? 1'b1 : float_r[i];
        end
    end
endmodule

`default_nettype wire

// ### bench/test_sgp_port.sv
// Self-checking bench for the six-bit port: register bus tasks and pad observations.
// Assumes sgp_port and sgp_pad_model; clk_en is held high throughout.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end

module test_sgp_port;
    import sgp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    sgp_addr_t reg_addr = 4'h0;
    sgp_data_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    sgp_data_t reg_rdata;
    sgp_pins_t pad_in, pad_out, pad_oe, pad_slew_limit, pad_ttl_sel, pad_pullup_en, pin_level;
    sgp_pins_t periph_override = 6'h00;
    sgp_pins_t periph_value = 6'h00;
    sgp_pins_t periph_open_drain = 6'h00;
    sgp_pins_t analog_out_en = 6'h00;
    logic master_clear_enable = 1'b0;
    sgp_pins_t ext_val = 6'h3f;
    sgp_pins_t ext_en = 6'h3f;
    int n_errors = 0;
    int cmp_count = 0;
    sgp_data_t rv [8] = '{8'h08, 8'h00, 8'h3f, 8'h37, 8'h00, 8'h00, 8'h37, 8'h3f};

    always #50 ref_clk = ~ref_clk;

    sgp_port i_sgp_port (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_slew_limit(pad_slew_limit), .pad_ttl_sel(pad_ttl_sel),
        .pad_pullup_en(pad_pullup_en), .pin_level(pin_level), .periph_override(periph_override),
        .periph_value(periph_value), .periph_open_drain(periph_open_drain), .analog_out_en(analog_out_en),
        .master_clear_enable(master_clear_enable));

    sgp_pad_model i_sgp_pad_model (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pad_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

    task automatic wr(input sgp_addr_t a, input sgp_data_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input sgp_addr_t a, input sgp_data_t ex);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", ex, reg_rdata)
    endtask

    // Covers the pad output register plus the two-flop input synchroniser.
    task automatic settle();
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic summarize();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #(3000 * 100);
        n_errors++;
        summarize();
    end

    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        `CHK("pad_oe", 6'h00, pad_oe)
        `CHK("pad_slew_limit", 6'h37, pad_slew_limit)
        for (int a = 0; a < 8; a++) rd(sgp_addr_t'(a), rv[a]);
        rd(4'h9, 8'h00);
        wr(4'h3, 8'h00);
        ext_val <= 6'h2a;
        settle();
        rd(4'h0, 8'h2a);
        `CHK("pin_level", 6'h2a, pin_level)
        wr(4'h3, 8'h03);
        settle();
        rd(4'h0, 8'h28);
        wr(4'h3, 8'h00);
        settle();
        wr(4'h8, 8'h10);
        rd(4'h1, 8'h23);
        wr(4'h8, 8'h06);
        rd(4'h1, 8'h23);
        wr(4'h0, 8'h15);
        rd(4'h1, 8'h15);
        rd(4'h0, 8'h2a);
        wr(4'h1, 8'h3f);
        rd(4'h1, 8'h37);
        wr(4'h1, 8'h15);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h08);
        settle();
        `CHK("pad_oe", 6'h37, pad_oe)
        `CHK("pad_out", 6'h15, pad_out)
        rd(4'h0, 8'h1d);
        wr(4'h3, 8'h01);
        settle();
        `CHK("pad_oe", 6'h37, pad_oe)
        rd(4'h0, 8'h1c);
        periph_override <= 6'h01;
        analog_out_en <= 6'h02;
        settle();
        `CHK("pad_out", 6'h14, pad_out)
        `CHK("pad_oe", 6'h35, pad_oe)
        periph_override <= 6'h00;
        analog_out_en <= 6'h00;
        wr(4'h3, 8'h00);
        wr(4'h5, 8'h04);
        wr(4'h4, 8'h3f);
        settle();
        `CHK("pad_oe", 6'h33, pad_oe)
        `CHK("pad_out", 6'h11, pad_out)
        `CHK("pad_pullup_en", 6'h0c, pad_pullup_en)
        periph_open_drain <= 6'h01;
        settle();
        `CHK("pad_oe", 6'h32, pad_oe)
        `CHK("pad_pullup_en", 6'h0d, pad_pullup_en)
        wr(4'h1, 8'h00);
        settle();
        `CHK("pad_oe", 6'h37, pad_oe)
        `CHK("pad_pullup_en", 6'h08, pad_pullup_en)
        wr(4'h4, 8'h00);
        ext_val <= 6'h00;
        master_clear_enable <= 1'b1;
        settle();
        `CHK("pad_pullup_en", 6'h08, pad_pullup_en)
        rd(4'h0, 8'h08);
        wr(4'h6, 8'h05);
        wr(4'h7, 8'h12);
        settle();
        `CHK("pad_slew_limit", 6'h05, pad_slew_limit)
        `CHK("pad_ttl_sel", 6'h12, pad_ttl_sel)
        summarize();
    end
endmodule

`default_nettype wire
